// ===== design/flc_top.sv
// Purpose: per-FIFO link configuration registers, routing and FIFO interrupt logic
// Assumes: one clock, synchronous active-high reset, classic Wishbone slave
// Notes: Functional notes below; one level interrupt output
`timescale 1ns/100ps
`default_nettype none
module flc_top
    import flc_pkg::*;
(
    input wire logic clk_i,                       // 20 MHz clock
    input wire logic rst_i,                       // synchronous reset, high
    input wire logic wb_cyc_i,                    // wishbone cycle
    input wire logic wb_stb_i,                    // wishbone strobe
    input wire logic wb_we_i,                     // wishbone write
    input wire logic [7:0] wb_adr_i,              // wishbone byte address
    input wire logic [3:0] wb_sel_i,              // wishbone byte lanes
    input wire logic [31:0] wb_dat_i,             // wishbone write data
    output logic [31:0] wb_dat_o,                 // wishbone read data
    output logic wb_ack_o,                        // wishbone ack
    input wire logic [FLC_IDX_W-1:0] act_idx_i,   // FIFO index being served
    input wire logic act_dir_i,                   // direction being served
    input wire logic [FLC_CNT_W-1:0] act_cnt_i,   // read (tx) or write (rx) counter
    input wire logic act_cnt_step_i,              // counter advanced this cycle
    input wire logic act_frame_end_i,             // frame completed this cycle
    output logic act_enabled_o,                   // served FIFO enabled
    output logic act_transparent_o,               // served FIFO transparent
    output flc_route_t act_route_o,               // served FIFO data paths
    output logic irq_o                            // level interrupt
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [FLC_SLOT_NUM-1:0][7:0] cfg;
        logic [FLC_IDX_W-1:0] sel_idx;
        logic sel_dir;
        logic [FLC_SLOT_NUM-1:0] mix;
        logic [FLC_SLOT_NUM-1:0] pend;
        logic [FLC_EVT_W-1:0] stat;
        logic [FLC_EVT_W-1:0] mask;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } flc_state_t;

    flc_state_t st;
    flc_state_t next_st;

    function automatic logic [FLC_SLOT_W-1:0] slot_of(input logic [FLC_IDX_W-1:0] idx,
                                                      input logic dir);
        slot_of = {idx, dir};
    endfunction

    // block wrap: low v+2 bits go from all ones to all zeros
    function automatic logic block_wrap(input logic [2:0] v, input logic [FLC_CNT_W-1:0] cnt);
        logic [FLC_CNT_W-1:0] low_mask;
        low_mask = '0;
        block_wrap = 1'b0;
        if (v != FLC_IRQ_OFF && v <= FLC_IRQ_MAX_BLOCK) begin
            low_mask = FLC_CNT_W'((9'h001 << ({1'b0, v} + FLC_BLOCK_BIAS)) - 9'h001);
            block_wrap = ((cnt & low_mask) == '0);
        end
    endfunction

    logic [FLC_SLOT_W-1:0] sel_slot;
    logic [FLC_SLOT_W-1:0] act_slot;
    logic [7:0] act_cfg;
    logic [2:0] act_irq_cfg;
    logic sel_enabled;
    logic sel_transparent;
    flc_route_t sel_route;
    logic req;
    logic blk_evt;
    logic frm_evt;
    logic [FLC_EVT_W-1:0] evt;

    assign sel_slot = slot_of(st.sel_idx, st.sel_dir);
    assign act_slot = slot_of(act_idx_i, act_dir_i);
    assign act_cfg = st.cfg[act_slot];
    assign act_irq_cfg = act_cfg[FLC_POS_IRQ_HI:FLC_POS_IRQ_LO];
    assign req = wb_cyc_i && wb_stb_i && !st.ack;

    flc_route_dec u_act_dec (
        .cfg_i(act_cfg),
        .dir_i(act_dir_i),
        .enabled_o(act_enabled_o),
        .transparent_o(act_transparent_o),
        .route_o(act_route_o)
    );

    flc_route_dec u_sel_dec (
        .cfg_i(st.cfg[sel_slot]),
        .dir_i(st.sel_dir),
        .enabled_o(sel_enabled),
        .transparent_o(sel_transparent),
        .route_o(sel_route)
    );

    // ****************************************
    // FIFO interrupt events
    // ****************************************
    always_comb begin
        blk_evt = 1'b0;
        frm_evt = 1'b0;
        if (act_enabled_o) begin
            if (act_transparent_o && act_cnt_step_i) begin
                blk_evt = block_wrap(act_irq_cfg, act_cnt_i);
            end
            if (!act_transparent_o) begin
                frm_evt = act_frame_end_i;
                if (st.mix[act_slot] && act_cnt_step_i) begin
                    blk_evt = block_wrap(act_irq_cfg, act_cnt_i);
                end
            end
        end
        evt = '0;
        evt[FLC_EVT_BLOCK] = blk_evt;
        evt[FLC_EVT_FRAME] = frm_evt;
        evt[FLC_EVT_DROP] = !act_enabled_o && (act_cnt_step_i || act_frame_end_i);
    end

    // ****************************************
    // registers and bus
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.rdata = '0;
        if (act_enabled_o && (blk_evt || frm_evt)) begin
            next_st.pend[act_slot] = 1'b1;
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                FLC_OFS_SELECT: next_st.rdata = {27'h0, st.sel_idx, st.sel_dir};
                FLC_OFS_LINK_CFG: next_st.rdata = {24'h0, st.cfg[sel_slot]};
                FLC_OFS_FIFO_CTRL: next_st.rdata = {31'h0, st.mix[sel_slot]};
                FLC_OFS_IRQ_STAT: next_st.rdata = {29'h0, st.stat};
                FLC_OFS_IRQ_MASK: next_st.rdata = {29'h0, st.mask};
                FLC_OFS_STATUS: next_st.rdata = st.pend;
                default: next_st.rdata = '0;
            endcase
            if (wb_adr_i == FLC_OFS_SELECT) begin
                next_st.rdata[8] = sel_enabled;
                next_st.rdata[9] = sel_transparent;
                next_st.rdata[15:10] = sel_route;
            end
        end
        if (req && wb_we_i && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                FLC_OFS_SELECT: begin
                    next_st.sel_dir = wb_dat_i[0];
                    next_st.sel_idx = wb_dat_i[FLC_IDX_W:1];
                end
                FLC_OFS_LINK_CFG: next_st.cfg[sel_slot] = wb_dat_i[7:0];
                FLC_OFS_FIFO_CTRL: next_st.mix[sel_slot] = wb_dat_i[0];
                FLC_OFS_IRQ_MASK: next_st.mask = wb_dat_i[FLC_EVT_W-1:0];
                default: ;
            endcase
        end
        // set wins over write-one-to-clear
        if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == FLC_OFS_IRQ_STAT) begin
            next_st.stat = st.stat & ~wb_dat_i[FLC_EVT_W-1:0];
        end
        if (req && wb_we_i && wb_adr_i == FLC_OFS_STATUS) begin
            next_st.pend = st.pend & ~wb_dat_i;
            if (act_enabled_o && (blk_evt || frm_evt)) begin
                next_st.pend[act_slot] = 1'b1;
            end
        end
        next_st.stat = next_st.stat | evt;
        next_st.irq = |(next_st.stat & next_st.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            for (int i = 0; i < FLC_SLOT_NUM; i++) begin
                st.cfg[i] <= FLC_LINK_CFG_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign irq_o = st.irq;

    // ****************************************
    // checks
    // ****************************************
    // disabled no paths
    disabled_no_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !act_enabled_o |-> act_route_o == '0)
        else $error("disabled FIFO has an active path");
    zero_disables_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_irq_cfg == FLC_IRQ_OFF) |-> !act_enabled_o && !blk_evt && !frm_evt)
        else $error("zero field left FIFO enabled");
    high_silent_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_transparent_o && act_irq_cfg > FLC_IRQ_MAX_BLOCK) |-> !blk_evt)
        else $error("block interrupt from value 6 or 7");
    wrap_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (blk_evt && !(req && wb_we_i)) |=> st.stat[FLC_EVT_BLOCK])
        else $error("block event not recorded");
    frame_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_enabled_o && !act_transparent_o && act_frame_end_i) |=> st.stat[FLC_EVT_FRAME])
        else $error("frame end not recorded");
    no_mix_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!act_transparent_o && !st.mix[act_slot]) |-> !blk_evt)
        else $error("HDLC block interrupt without mixed option");
    line_pcm_tx_a: assert property (@(posedge clk_i) disable iff (rst_i)
        act_route_o.line_to_pcm |-> act_dir_i == FLC_TX)
        else $error("line to PCM on receive FIFO");
    pcm_line_stored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        act_route_o.pcm_to_line |-> act_route_o.pcm_to_fifo)
        else $error("PCM to line not stored");
    cfg_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && wb_we_i && wb_sel_i[0] && wb_adr_i == FLC_OFS_LINK_CFG)
        |=> st.cfg[$past(sel_slot)][FLC_POS_MODE] == $past(wb_dat_i[FLC_POS_MODE]))
        else $error("mode bit not stored");
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    tx_line_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_enabled_o && act_dir_i == FLC_TX)
        |-> act_route_o.fifo_to_line == !act_cfg[FLC_POS_FLOW_HI-1])
        else $error("transmit FIFO to line path wrong");
    tx_pcm_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_enabled_o && act_dir_i == FLC_TX)
        |-> act_route_o.line_to_pcm == act_cfg[FLC_POS_FLOW_HI]
            && act_route_o.fifo_to_pcm == !act_cfg[FLC_POS_FLOW_HI])
        else $error("transmit PCM source wrong");
    pcm_only_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_enabled_o && act_dir_i == FLC_TX
            && act_cfg[FLC_POS_FLOW_HI:FLC_POS_FLOW_HI-1] == 2'h1)
        |-> act_route_o.fifo_to_pcm && !act_route_o.fifo_to_line && !act_route_o.line_to_pcm)
        else $error("code pair 01 not PCM only");
    tx_paths_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_dir_i == FLC_TX)
        |-> !act_route_o.line_to_fifo && !act_route_o.pcm_to_fifo && !act_route_o.pcm_to_line)
        else $error("receive path on transmit FIFO");
    rx_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_enabled_o && act_dir_i == FLC_RX)
        |-> act_route_o.line_to_fifo == !act_cfg[FLC_POS_FLOW_LO]
            && act_route_o.pcm_to_line == act_cfg[FLC_POS_FLOW_LO+1])
        else $error("receive routing wrong");
    rx_paths_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_dir_i == FLC_RX)
        |-> !act_route_o.fifo_to_line && !act_route_o.fifo_to_pcm)
        else $error("transmit path on receive FIFO");
    nonzero_enables_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (act_irq_cfg != FLC_IRQ_OFF) |-> act_enabled_o)
        else $error("nonzero field left FIFO disabled");
    trp_no_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
        act_transparent_o |-> !frm_evt)
        else $error("frame event in transparent mode");
    drop_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!act_enabled_o && (act_cnt_step_i || act_frame_end_i)) |=> st.stat[FLC_EVT_DROP])
        else $error("activity on disabled FIFO not recorded");
    pend_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        frm_evt |=> st.pend[$past(act_slot)])
        else $error("frame end slot not pending");
    stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && wb_we_i && wb_sel_i[0] && wb_adr_i == FLC_OFS_IRQ_STAT
            && wb_dat_i[FLC_EVT_FRAME] && !frm_evt) |=> !st.stat[FLC_EVT_FRAME])
        else $error("frame flag not cleared");
    read_idle_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
endmodule
`default_nettype wire

// ===== design/flc_pkg.sv
// Purpose: constants and types for the per-FIFO link configuration block
// Assumes: classic Wishbone register access, 32-bit data, word-aligned registers
// Notes: one configuration byte per FIFO index and direction
`default_nettype none
package flc_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int FLC_FIFO_NUM = 16;
    localparam int FLC_IDX_W = 4;
    localparam int FLC_SLOT_NUM = 32;
    localparam int FLC_SLOT_W = 5;
    localparam int FLC_CNT_W = 8;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] FLC_OFS_SELECT = 8'h00;
    localparam logic [7:0] FLC_OFS_LINK_CFG = 8'h04;
    localparam logic [7:0] FLC_OFS_FIFO_CTRL = 8'h08;
    localparam logic [7:0] FLC_OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] FLC_OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] FLC_OFS_STATUS = 8'h14;

    // ****************************************
    // field positions of the link configuration byte
    // ****************************************
    localparam int FLC_POS_FILL = 0;
    localparam int FLC_POS_MODE = 1;
    localparam int FLC_POS_IRQ_LO = 2;
    localparam int FLC_POS_IRQ_HI = 4;
    localparam int FLC_POS_FLOW_LO = 5;
    localparam int FLC_POS_FLOW_HI = 7;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0] FLC_LINK_CFG_RST = 8'h00;
    localparam logic [2:0] FLC_IRQ_OFF = 3'h0;
    localparam logic [2:0] FLC_IRQ_MAX_BLOCK = 3'h5;
    localparam logic [3:0] FLC_BLOCK_BIAS = 4'h2;
    localparam int FLC_EVT_W = 3;
    localparam int FLC_EVT_BLOCK = 0;
    localparam int FLC_EVT_FRAME = 1;
    localparam int FLC_EVT_DROP = 2;

    // ****************************************
    // data flow routing
    // ****************************************
    typedef struct packed {
        logic fifo_to_line;
        logic fifo_to_pcm;
        logic line_to_pcm;
        logic line_to_fifo;
        logic pcm_to_fifo;
        logic pcm_to_line;
    } flc_route_t;

    typedef enum logic {
        FLC_TX = 1'b0,
        FLC_RX = 1'b1
    } flc_dir_t;

endpackage
`default_nettype wire

// ===== design/flc_route_dec.sv
// Purpose: decodes mode, enable and routing of one FIFO from its configuration byte
// Assumes: combinational, used by the main register block
// Notes: a disabled FIFO yields an all-zero route
`timescale 1ns/100ps
`default_nettype none
module flc_route_dec
    import flc_pkg::*;
(
    input wire logic [7:0] cfg_i,     // configuration byte of the FIFO
    input wire logic dir_i,           // 0 transmit, 1 receive
    output logic enabled_o,           // FIFO enabled
    output logic transparent_o,       // transparent byte processing
    output flc_route_t route_o        // active data paths
);
    logic [2:0] flow;
    logic [2:0] irq_cfg;

    assign flow = cfg_i[FLC_POS_FLOW_HI:FLC_POS_FLOW_LO];
    assign irq_cfg = cfg_i[FLC_POS_IRQ_HI:FLC_POS_IRQ_LO];
    assign transparent_o = cfg_i[FLC_POS_MODE];
    assign enabled_o = (irq_cfg != FLC_IRQ_OFF);

    always_comb begin
        route_o = '0;
        if (dir_i == FLC_TX) begin
            unique case (flow[2:1])
                2'h0: begin
                    route_o.fifo_to_line = 1'b1;
                    route_o.fifo_to_pcm = 1'b1;
                end
                2'h1: route_o.fifo_to_pcm = 1'b1;
                2'h2: begin
                    route_o.fifo_to_line = 1'b1;
                    route_o.line_to_pcm = 1'b1;
                end
                2'h3: route_o.line_to_pcm = 1'b1;
            endcase
        end else begin
            route_o.line_to_fifo = ~flow[0];
            route_o.pcm_to_fifo = flow[0];
            route_o.pcm_to_line = flow[1];
            if (flow[1]) begin
                route_o.pcm_to_fifo = 1'b1;
            end
        end
        if (!enabled_o) begin
            route_o = '0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/flc_sw_model.sv
// Purpose: software side, a classic wishbone master that configures FIFOs
// Assumes: one clock, the slave always answers with ack
// Notes: signals change only right after a rising edge
`timescale 1ns/100ps
`default_nettype none
module flc_sw_model (
    input wire logic clk_i,         // bus clock
    input wire logic ack_i,         // slave ack
    input wire logic [31:0] dat_i,  // read data
    output var logic cyc_o,         // cycle
    output var logic stb_o,         // strobe
    output var logic we_o,          // write
    output var logic [3:0] sel_o,   // byte lanes
    output var logic [7:0] adr_o,   // byte address
    output var logic [31:0] dat_o   // write data
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        sel_o = 4'hF;
        adr_o = 8'h00;
        dat_o = 32'h0;
    end

    task automatic xfer_lanes(input logic w, input logic [7:0] a, input logic [31:0] d,
                              input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        sel_o <= s;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        xfer_lanes(w, a, d, 4'hF, q);
    endtask

    task automatic set_cfg(input logic [3:0] i, input logic d, input logic [7:0] v);
        logic [31:0] q;
        xfer(1'b1, 8'h00, {27'h0, i, d}, q);
        xfer(1'b1, 8'h04, {24'h0, v}, q);
    endtask
endmodule
`default_nettype wire

// ===== testbench/fifo_channel_link_config_tb.sv
// Purpose: self-checking bench for the per-FIFO link configuration block
// Assumes: 20 MHz clock, reset held 12 cycles
// Notes: routing and interrupt expectations come from integer models
`timescale 1ns/100ps
`default_nettype none
module fifo_channel_link_config_tb
    import flc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq, en, trp;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [3:0] act_idx = 4'h0;
    logic act_dir = 1'b0;
    logic [7:0] act_cnt = 8'h00;
    logic step = 1'b0;
    logic fend = 1'b0;
    flc_route_t route;
    int num_errors = 0;
    int checks = 0;
    int seed = 32;

    always #25 clk_i = ~clk_i;

    flc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .act_idx_i(act_idx), .act_dir_i(act_dir),
        .act_cnt_i(act_cnt), .act_cnt_step_i(step), .act_frame_end_i(fend),
        .act_enabled_o(en), .act_transparent_o(trp), .act_route_o(route), .irq_o(irq));

    flc_sw_model u_sw (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic int exp_route(int d, int c, int v);
        int tx_tab[4] = '{48, 16, 40, 8};
        if (v == 0) return 0;
        if (d == 0) return tx_tab[c >> 1];
        return ((c & 1) ? 0 : 4) + (((c & 3) != 0) ? 2 : 0) + ((c & 2) ? 1 : 0);
    endfunction

    task automatic cfg(input int i, input int d, input logic [7:0] v);
        u_sw.set_cfg(i[3:0], d[0], v);
        act_idx <= i[3:0];
        act_dir <= d[0];
        @(posedge clk_i);
        #1;
    endtask

    task automatic steps(input int a, input int b);
        for (int k = a; k <= b; k++) begin
            @(posedge clk_i);
            act_cnt <= k[7:0];
            step <= 1'b1;
        end
        @(posedge clk_i);
        step <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic frame();
        @(posedge clk_i);
        fend <= 1'b1;
        @(posedge clk_i);
        fend <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic clear_irq();
        u_sw.xfer(1'b1, FLC_OFS_IRQ_STAT, 32'h7, q);
        @(posedge clk_i);
        #1;
        check(irq, 0);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        int i, v, m, n;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a <= 32; a += 4) begin
            u_sw.xfer(1'b0, 8'(a), 32'h0, q);
            check(q, 0);
        end
        $display("reset test done");
        // random mode, zero value forced at code 3, random value elsewhere that may also be zero
        for (int d = 0; d < 2; d++) begin
            for (int c = 0; c < 8; c++) begin
                i = $random(seed) & 15;
                v = (c == 3) ? 0 : ($random(seed) & 7);
                m = $random(seed) & 1;
                cfg(i, d, 8'(c * 32 + v * 4 + m * 2));
                check(en, v != 0);
                check(trp, m);
                check(route, exp_route(d, c, v));
                u_sw.xfer(1'b0, FLC_OFS_LINK_CFG, 32'h0, q);
                check(q, c * 32 + v * 4 + m * 2);
                u_sw.xfer(1'b0, FLC_OFS_SELECT, 32'h0, q);
                n = (exp_route(d, c, v) << 10) + m * 512 + (v != 0) * 256 + i * 2 + d;
                check(q, n);
            end
        end
        $display("routing test done");
        cfg(2, 1, 8'h04);
        frame();
        check(irq, 0);
        u_sw.xfer(1'b0, FLC_OFS_IRQ_STAT, 32'h0, q);
        check(q[1], 1);
        u_sw.xfer(1'b0, FLC_OFS_STATUS, 32'h0, q);
        check(q, 32'h20);
        u_sw.xfer_lanes(1'b1, FLC_OFS_STATUS, 32'h20, 4'h0, q);
        u_sw.xfer(1'b0, FLC_OFS_STATUS, 32'h0, q);
        check(q, 0);
        u_sw.xfer(1'b1, FLC_OFS_IRQ_MASK, 32'h3, q);
        @(posedge clk_i);
        #1;
        check(irq, 1);
        clear_irq();
        steps(1, 8);
        check(irq, 0);
        u_sw.xfer(1'b1, FLC_OFS_FIFO_CTRL, 32'h1, q);
        steps(1, 8);
        check(irq, 1);
        clear_irq();
        cfg(2, 1, 8'h00);
        frame();
        check(irq, 0);
        u_sw.xfer(1'b0, FLC_OFS_IRQ_STAT, 32'h0, q);
        check(q, 4);
        $display("frame test done");
        for (v = 1; v < 8; v++) begin
            cfg(v, 0, 8'(v * 4 + 2));
            n = (v < 6) ? (1 << (v + 2)) : 256;
            steps(1, n - 1);
            check(irq, 0);
            steps(n, n);
            check(irq, v < 6);
            clear_irq();
        end
        $display("block test done");
        u_sw.xfer_lanes(1'b1, FLC_OFS_LINK_CFG, 32'hFF, 4'h0, q);
        u_sw.xfer(1'b0, FLC_OFS_LINK_CFG, 32'h0, q);
        check(q, 32'h1E);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        u_sw.xfer(1'b0, FLC_OFS_LINK_CFG, 32'h0, q);
        check(q, 0);
        check(en, 0);
        check(irq, 0);
        $display("lane and reset test done");
        stop_test();
    end

    initial begin
        #(50 * 20000);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
